/* verilog/erx_pkg.sv */
// package: constants for the explicit receive frame builder
package erx_pkg;
  localparam logic [7:0] ERX_START_DELIM = 8'h7E;
  localparam logic [7:0] ERX_TYPE_EXPLICIT = 8'h91;
  localparam logic [7:0] ERX_TYPE_STANDARD = 8'h90;
  localparam logic [15:0] ERX_RESERVED_WORD = 16'hFFFE;
  localparam logic [7:0] ERX_CKSUM_BASE = 8'hFF;
  // bytes between length and checksum, payload excluded
  localparam logic [15:0] ERX_HDR_EXPLICIT = 16'h0012;
  localparam logic [15:0] ERX_HDR_STANDARD = 16'h000C;
  localparam int ERX_OPT_EXPLICIT_BIT = 1;
  localparam int ERX_OPT_ACK_BIT = 0;
  localparam int ERX_OPT_BCAST_BIT = 1;
  localparam int ERX_OPT_METHOD_LSB = 6;
  // apb register byte addresses
  localparam logic [11:0] ERX_ADDR_CTRL = 12'h000;
  localparam logic [11:0] ERX_ADDR_STATUS = 12'h004;
  localparam logic [11:0] ERX_ADDR_COUNT = 12'h008;
  localparam logic [7:0] ERX_CTRL_RESET = 8'h00;
  localparam int ERX_FIFO_DEPTH = 16;
  typedef enum logic [7:0] {
    ERX_IDLE  = 8'h01,
    ERX_HEAD  = 8'h02,
    ERX_ADDR  = 8'h04,
    ERX_EXPL  = 8'h08,
    ERX_OPTS  = 8'h10,
    ERX_DATA  = 8'h20,
    ERX_CKSUM = 8'h40,
    ERX_DONE  = 8'h80
  } erx_state_t;
endpackage

/* verilog/erx_frame_builder.sv */
// explicit receive frame builder with apb control and output fifo
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------
// byte fifo
// ------------------------------------------------------------
module erx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_wr_valid,
  output logic o_wr_ready,
  input wire logic [WIDTH-1:0] i_wr_data,
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic [WIDTH-1:0] o_rd_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } erx_fifo_st_t;
  erx_fifo_st_t s_q, s_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic wr_en, rd_en;
  // ------------------------------------------------------------
  // occupancy flags
  // ------------------------------------------------------------
  // the extra count bit tells full from empty, since the two
  // pointers are equal in both cases
  assign o_wr_ready = (s_q.cnt != (AW+1)'(DEPTH));
  assign o_rd_valid = (s_q.cnt != '0);
  assign wr_en = i_wr_valid && o_wr_ready;
  assign rd_en = o_rd_valid && i_rd_ready;
  // storage is not reset, so the head word means nothing while
  // o_rd_valid is low
  assign o_rd_data = mem[s_q.rp];
  // ------------------------------------------------------------
  // pointer and count update
  // ------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    if (wr_en) begin
      s_d.wp = s_q.wp + 1'b1;
    end
    if (rd_en) begin
      s_d.rp = s_q.rp + 1'b1;
    end
    if (wr_en && !rd_en) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end else if (rd_en && !wr_en) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
  end
  // ------------------------------------------------------------
  // registers and storage
  // ------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
    if (wr_en) begin
      mem[s_q.wp] <= i_wr_data;
    end
  end
endmodule

// ------------------------------------------------------------
// frame builder top
// ------------------------------------------------------------
module erx_frame_builder import erx_pkg::*; #(
  parameter int FIFO_DEPTH = ERX_FIFO_DEPTH
) (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_SRST,
  // apb slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // packet descriptor from receive path
  input wire logic I_PKT_VALID,
  output logic O_PKT_READY,
  input wire logic [63:0] I_PKT_SRC_ADDR,
  input wire logic [7:0] I_PKT_SRC_EP,
  input wire logic [7:0] I_PKT_DST_EP,
  input wire logic [15:0] I_PKT_CLUSTER,
  input wire logic [15:0] I_PKT_PROFILE,
  input wire logic I_PKT_ACKED,
  input wire logic I_PKT_BCAST,
  input wire logic [1:0] I_PKT_METHOD,
  input wire logic [15:0] I_PKT_LEN,
  // payload byte stream
  input wire logic I_PLD_VALID,
  output logic O_PLD_READY,
  input wire logic [7:0] I_PLD_DATA,
  // serial frame byte stream
  output logic O_TX_VALID,
  input wire logic I_TX_READY,
  output logic [7:0] O_TX_DATA
);
  // ------------------------------------------------------------
  // state record
  // ------------------------------------------------------------
  // rdata holds the word captured in the apb setup cycle
  typedef struct packed {
    erx_state_t st;
    logic explicit_m;
    logic [63:0] src;
    logic [7:0] sep;
    logic [7:0] dep;
    logic [15:0] clu;
    logic [15:0] pro;
    logic [7:0] opt;
    logic [15:0] plen;
    logic [15:0] len;
    logic [4:0] idx;
    logic [15:0] left;
    logic [7:0] sum;
    logic [7:0] ctrl;
    logic [15:0] frames;
    logic [31:0] rdata;
  } erx_st_t;
  erx_st_t s_q, s_d;

  logic f_wr_valid, f_wr_ready;
  logic [7:0] f_wr_data;
  logic apb_acc, apb_wr, apb_cap;

  // ------------------------------------------------------------
  // output fifo
  // ------------------------------------------------------------
  // back-pressure from the host stalls the builder via f_wr_ready
  erx_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk(I_CLK),
    .i_srst(I_SRST),
    .i_wr_valid(f_wr_valid),
    .o_wr_ready(f_wr_ready),
    .i_wr_data(f_wr_data),
    .o_rd_valid(O_TX_VALID),
    .i_rd_ready(I_TX_READY),
    .o_rd_data(O_TX_DATA)
  );

  // ------------------------------------------------------------
  // apb slave
  // ------------------------------------------------------------
  // true for the offsets that hold a register
  function automatic logic reg_mapped(input logic [11:0] a);
    if (a == ERX_ADDR_CTRL) begin
      reg_mapped = 1'b1;
    end else if (a == ERX_ADDR_STATUS) begin
      reg_mapped = 1'b1;
    end else if (a == ERX_ADDR_COUNT) begin
      reg_mapped = 1'b1;
    end else begin
      reg_mapped = 1'b0;
    end
  endfunction

  // read data is captured in the setup cycle, so it already stands
  // in a flop at the access edge and no wait state is needed; the
  // price is that status is one cycle old when it is read
  assign apb_acc = I_PSEL && I_PENABLE;
  assign apb_wr = apb_acc && I_PWRITE;
  assign apb_cap = I_PSEL && !I_PENABLE && !I_PWRITE;
  assign O_PREADY = 1'b1;
  assign O_PRDATA = s_q.rdata;
  assign O_PSLVERR = apb_acc && !reg_mapped(I_PADDR);

  // ------------------------------------------------------------
  // stream handshakes
  // ------------------------------------------------------------
  // a descriptor is taken only in idle, so one frame is built at once
  assign O_PKT_READY = (s_q.st == ERX_IDLE);
  assign O_PLD_READY = (s_q.st == ERX_DATA) && f_wr_ready;

  // ------------------------------------------------------------
  // field byte selection
  // ------------------------------------------------------------
  // byte of the explicit-only header, idx 0..5 over bytes 14..19
  function automatic logic [7:0] expl_byte(input erx_st_t s);
    case (s.idx[2:0])
      3'h0: expl_byte = s.sep;
      3'h1: expl_byte = s.dep;
      3'h2: expl_byte = s.clu[15:8];
      3'h3: expl_byte = s.clu[7:0];
      3'h4: expl_byte = s.pro[15:8];
      default: expl_byte = s.pro[7:0];
    endcase
  endfunction

  // header byte: delimiter, length, type; idx 0..3
  function automatic logic [7:0] head_byte(input erx_st_t s);
    case (s.idx[1:0])
      2'h0: head_byte = ERX_START_DELIM;
      2'h1: head_byte = s.len[15:8];
      2'h2: head_byte = s.len[7:0];
      default: head_byte = s.explicit_m ? ERX_TYPE_EXPLICIT
                                         : ERX_TYPE_STANDARD;
    endcase
  endfunction

  // ------------------------------------------------------------
  // frame sequencing
  // ------------------------------------------------------------
  always_comb begin
    logic [7:0] b;
    logic push;
    b = 8'h00;
    push = 1'b0;
    s_d = s_q;
    f_wr_valid = 1'b0;
    f_wr_data = 8'h00;
    case (s_q.st)
      ERX_IDLE: begin
        if (I_PKT_VALID) begin
          // the option is sampled once per frame, so a control write
          // made while a frame is built applies to the next one
          s_d.explicit_m = s_q.ctrl[ERX_OPT_EXPLICIT_BIT];
          s_d.src = I_PKT_SRC_ADDR;
          s_d.sep = I_PKT_SRC_EP;
          s_d.dep = I_PKT_DST_EP;
          s_d.clu = I_PKT_CLUSTER;
          s_d.pro = I_PKT_PROFILE;
          // flags are independent bits that may combine
          s_d.opt = 8'h00;
          s_d.opt[ERX_OPT_ACK_BIT] = I_PKT_ACKED;
          s_d.opt[ERX_OPT_BCAST_BIT] = I_PKT_BCAST;
          s_d.opt[ERX_OPT_METHOD_LSB +: 2] = I_PKT_METHOD;
          s_d.plen = I_PKT_LEN;
          s_d.len = (s_q.ctrl[ERX_OPT_EXPLICIT_BIT] ? ERX_HDR_EXPLICIT
                     : ERX_HDR_STANDARD) + I_PKT_LEN;
          s_d.idx = '0;
          s_d.sum = 8'h00;
          s_d.st = ERX_HEAD;
        end
      end
      ERX_HEAD: begin
        b = head_byte(s_q);
        push = 1'b1;
      end
      ERX_ADDR: begin
        // idx 0..7 sender address msb first, 8..9 reserved word
        if (s_q.idx < 5'd8) begin
          b = s_q.src[63 - 8*s_q.idx[2:0] -: 8];
        end else if (s_q.idx == 5'd8) begin
          b = ERX_RESERVED_WORD[15:8];
        end else begin
          b = ERX_RESERVED_WORD[7:0];
        end
        push = 1'b1;
      end
      ERX_EXPL: begin
        b = expl_byte(s_q);
        push = 1'b1;
      end
      ERX_OPTS: begin
        b = s_q.opt;
        push = 1'b1;
      end
      ERX_DATA: begin
        // payload passes the fifo untouched; only the sum sees it
        f_wr_valid = I_PLD_VALID;
        f_wr_data = I_PLD_DATA;
        if (I_PLD_VALID && f_wr_ready) begin
          s_d.sum = s_q.sum + I_PLD_DATA;
          s_d.left = s_q.left - 16'h0001;
          if (s_q.left == 16'h0001) begin
            s_d.st = ERX_CKSUM;
          end
        end
      end
      ERX_CKSUM: begin
        f_wr_valid = 1'b1;
        f_wr_data = ERX_CKSUM_BASE - s_q.sum;
        if (f_wr_ready) begin
          s_d.st = ERX_DONE;
        end
      end
      ERX_DONE: begin
        // the frame counter wraps; software works with differences
        s_d.frames = s_q.frames + 16'h0001;
        s_d.st = ERX_IDLE;
      end
      default: begin
        s_d.st = ERX_IDLE;
      end
    endcase
    if (push) begin
      f_wr_valid = 1'b1;
      f_wr_data = b;
      if (f_wr_ready) begin
        // checksum covers everything from the type byte onward
        if (s_q.st != ERX_HEAD || s_q.idx == 5'd3) begin
          s_d.sum = s_q.sum + b;
        end
        s_d.idx = s_q.idx + 5'd1;
        s_d.left = s_q.plen;
        if (s_q.st == ERX_HEAD && s_q.idx == 5'd3) begin
          s_d.idx = '0;
          s_d.st = ERX_ADDR;
        end else if (s_q.st == ERX_ADDR && s_q.idx == 5'd9) begin
          // standard frame skips endpoints and identifiers
          s_d.idx = '0;
          s_d.st = s_q.explicit_m ? ERX_EXPL : ERX_OPTS;
        end else if (s_q.st == ERX_EXPL && s_q.idx == 5'd5) begin
          s_d.idx = '0;
          s_d.st = ERX_OPTS;
        end else if (s_q.st == ERX_OPTS) begin
          s_d.st = (s_q.plen == 16'h0000) ? ERX_CKSUM : ERX_DATA;
        end
      end
    end
    // register file
    // writes to unmapped or read-only offsets are dropped
    if (apb_wr && I_PADDR == ERX_ADDR_CTRL) begin
      s_d.ctrl = I_PWDATA[7:0];
    end
    if (apb_cap) begin
      if (I_PADDR == ERX_ADDR_CTRL) begin
        s_d.rdata = {24'h000000, s_q.ctrl};
      end else if (I_PADDR == ERX_ADDR_STATUS) begin
        s_d.rdata = {23'h000000, O_TX_VALID, s_q.st};
      end else if (I_PADDR == ERX_ADDR_COUNT) begin
        s_d.rdata = {16'h0000, s_q.frames};
      end else begin
        s_d.rdata = 32'h00000000;
      end
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      s_q <= '0;
      s_q.st <= ERX_IDLE;
      s_q.ctrl <= ERX_CTRL_RESET;
    end else begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

/* sim/erx_properties.sv */
// checker: port assertions for the explicit frame builder
`timescale 1ns/1ns
`default_nettype none
module erx_properties (
  input wire logic I_CLK,
  input wire logic I_SRST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  input wire logic I_PKT_VALID,
  input wire logic O_PKT_READY,
  input wire logic O_PLD_READY,
  input wire logic O_TX_VALID,
  input wire logic I_TX_READY,
  input wire logic [7:0] O_TX_DATA
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_SRST);
  a_reset_idle: assert property ($fell(I_SRST) |-> O_PKT_READY &&
    !O_TX_VALID && O_PRDATA == 32'h0) else $error("not idle after reset");
  a_no_wait: assert property (I_PSEL && I_PENABLE |-> O_PREADY)
    else $error("apb wait state");
  a_slverr_map: assert property (I_PSEL && I_PENABLE &&
    I_PADDR[1:0] == 2'h0 |-> O_PSLVERR == (I_PADDR > 12'h008))
    else $error("slave error wrong");
  a_bad_read: assert property (I_PSEL && I_PENABLE && !I_PWRITE &&
    O_PSLVERR |-> O_PRDATA == 32'h0) else $error("unmapped read not 0");
  a_frame_start: assert property (I_PKT_VALID && O_PKT_READY &&
    !O_TX_VALID |-> ##[1:4] O_TX_VALID && O_TX_DATA == 8'h7E)
    else $error("frame does not open with delimiter");
  a_busy_after: assert property (I_PKT_VALID && O_PKT_READY |=>
    !O_PKT_READY [*8]) else $error("descriptor taken too soon");
  a_pld_busy: assert property (O_PLD_READY |-> !O_PKT_READY)
    else $error("payload taken while idle");
  a_tx_hold: assert property (O_TX_VALID && !I_TX_READY |=>
    O_TX_VALID && $stable(O_TX_DATA)) else $error("stalled byte changed");
endmodule
bind erx_frame_builder erx_properties chk_u (.I_CLK, .I_SRST, .I_PSEL,
  .I_PENABLE, .I_PWRITE, .I_PADDR, .O_PRDATA, .O_PREADY, .O_PSLVERR,
  .I_PKT_VALID, .O_PKT_READY, .O_PLD_READY, .O_TX_VALID, .I_TX_READY,
  .O_TX_DATA);
`default_nettype wire

/* sim/erx_host_model.sv */
// host model: takes the serial frame stream, can stall or go slow
`timescale 1ns/1ns
`default_nettype none
module erx_host_model (
  input wire logic i_clk,
  input wire logic i_hold,
  input wire logic i_slow,
  input wire logic i_valid,
  input wire logic [7:0] i_data,
  output logic o_ready
);
  logic [7:0] rx[$];
  logic tgl_q = 1'h0;
  always @(posedge i_clk) begin
    // bytes kept whole so each field and the sum can be decoded apart
    if (i_valid && o_ready) rx.push_back(i_data);
    tgl_q <= !tgl_q;
    o_ready <= !i_hold && (!i_slow || tgl_q);
  end
endmodule
`default_nettype wire

/* sim/erx_frame_builder_tb_top.sv */
// bench: register and stream tests of the explicit frame builder
`timescale 1ns/1ns
`default_nettype none
module erx_frame_builder_tb_top;
  logic clk = 1'h0, srst = 1'h1, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
  logic pkv = 1'h0, pldv = 1'h0, hold = 1'h0, slow = 1'h0;
  logic ack = 1'h0, bc = 1'h0;
  logic [1:0] meth = 2'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [63:0] sa = 64'h0;
  logic [7:0] sep = 8'h0, dep = 8'h0, pld = 8'h0, txd;
  logic [15:0] clu = 16'h0, pro = 16'h0, plen = 16'h0;
  logic pready, pslverr, pkr, pldr, txv, txr;
  int errors = 0, cmp_count = 0;
  always #25 clk = !clk;
  erx_frame_builder #(.FIFO_DEPTH(16)) dut_u (.I_CLK(clk), .I_SRST(srst),
    .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_PKT_VALID(pkv), .O_PKT_READY(pkr),
    .I_PKT_SRC_ADDR(sa), .I_PKT_SRC_EP(sep), .I_PKT_DST_EP(dep),
    .I_PKT_CLUSTER(clu), .I_PKT_PROFILE(pro), .I_PKT_ACKED(ack),
    .I_PKT_BCAST(bc), .I_PKT_METHOD(meth), .I_PKT_LEN(plen),
    .I_PLD_VALID(pldv), .O_PLD_READY(pldr), .I_PLD_DATA(pld),
    .O_TX_VALID(txv), .I_TX_READY(txr), .O_TX_DATA(txd));
  erx_host_model host_u (.i_clk(clk), .i_hold(hold), .i_slow(slow),
    .i_valid(txv), .i_data(txd), .o_ready(txr));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ready is sampled at the rising edge that takes the transfer
  task automatic hs(input int k);
    int i;
    for (i = 0; i < 400; i++) begin
      @(posedge clk);
      if (k == 0 ? pready : k == 1 ? pkr : pldr) break;
    end
    if (i == 400) begin
      errors++;
      conclude();
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, input logic e);
    psel <= 1'h1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'h1;
    hs(0);
    rd = prdata;
    chk(pslverr, e);
    psel <= 1'h0;
    pen <= 1'h0;
    @(posedge clk);
  endtask
  task automatic frame(input logic x, input int n, input logic [1:0] m,
      input logic a, input logic c);
    logic [7:0] b[$], ef[$], s;
    int i;
    meth <= m;
    ack <= a;
    bc <= c;
    plen <= 16'(n);
    sa <= 64'h0011223344556677 + 64'(n);
    sep <= 8'hDC + 8'(n);
    clu <= 16'h0011 + 16'(n);
    pro <= 16'h1234;
    dep <= 8'hEE;
    pkv <= 1'h1;
    hs(1);
    pkv <= 1'h0;
    b = {(x ? 8'h91 : 8'h90)};
    for (i = 7; i >= 0; i--) b.push_back(sa[i*8+:8]);
    b = {b, 8'hFF, 8'hFE};
    if (x) b = {b, sep, dep, clu[15:8], clu[7:0], pro[15:8], pro[7:0]};
    b.push_back({m, 4'h0, c, a});
    for (i = 0; i < n; i++) begin
      pldv <= 1'h1;
      pld <= 8'(i * 37 + n);
      b.push_back(8'(i * 37 + n));
      hs(2);
    end
    pldv <= 1'h0;
    s = 8'h0;
    foreach (b[j]) s += b[j];
    ef = {8'h7E, 8'(b.size() >> 8), 8'(b.size()), b, 8'hFF - s};
    for (i = 0; i < 3000 && host_u.rx.size() < ef.size(); i++)
      @(posedge clk);
    if (i == 3000) begin
      errors++;
      conclude();
    end
    chk(host_u.rx.size(), ef.size());
    foreach (ef[j]) chk(host_u.rx[j], ef[j]);
    host_u.rx.delete();
  endtask
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'h0;
    @(posedge clk);
    apb(1'h1, 12'h010, 32'hFF, 1'h1);
    apb(1'h0, 12'h00C, 32'h0, 1'h1);
    chk(rd, 32'h0);
    apb(1'h0, 12'h000, 32'h0, 1'h0);
    chk(rd, 32'h0);
    frame(1'h0, 0, 2'h3, 1'h1, 1'h1);
    apb(1'h1, 12'h000, 32'h1, 1'h0);
    frame(1'h0, 3, 2'h1, 1'h0, 1'h1);
    apb(1'h1, 12'h000, 32'h2, 1'h0);
    for (int m = 0; m < 4; m++) frame(1'h1, m * 5 + 1, 2'(m), m[0], m[1]);
    hold <= 1'h1;
    slow <= 1'h1;
    fork
      begin
        repeat (80) @(posedge clk);
        hold <= 1'h0;
      end
    join_none
    frame(1'h1, 24, 2'h2, 1'h1, 1'h0);
    apb(1'h0, 12'h008, 32'h0, 1'h0);
    chk(rd, 32'h7);
    apb(1'h0, 12'h004, 32'h0, 1'h0);
    chk(rd, 32'h1);
    conclude();
  end
endmodule
`default_nettype wire
